// ### mmios_pkg.sv
// Package of offsets, bit positions and reset values for the motion module I/O image.
// Assumes a single 250 MHz clock shared with the backplane logic.
package mmios_pkg;
	// ----------------------------------------------------------------
	// Image words
	// ----------------------------------------------------------------
	localparam int MMIOS_WORD_W = 16;
	localparam int MMIOS_AXES = 32;
	localparam logic [1:0] MMIOS_OFS_STATUS = 2'h0;
	localparam logic [1:0] MMIOS_OFS_AXIS_LOW = 2'h1;
	localparam logic [1:0] MMIOS_OFS_AXIS_HIGH = 2'h2;
	localparam logic [1:0] MMIOS_OFS_COMMAND = 2'h3;
	// ----------------------------------------------------------------
	// Status word and command word bit positions
	// ----------------------------------------------------------------
	localparam int MMIOS_ST_STOP = 0;
	localparam int MMIOS_ST_ERROR = 1;
	localparam int MMIOS_ST_COMM = 2;
	localparam int MMIOS_ST_LINK = 14;
	localparam int MMIOS_ST_READY = 15;
	localparam int MMIOS_CMD_STOP = 0;
	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [15:0] MMIOS_CMD_RESET = 16'h0001;
	localparam logic [15:0] MMIOS_STATUS_RESET = 16'h0001;
	localparam logic [15:0] MMIOS_ZERO_WORD = 16'h0000;
endpackage

// ### mmios_axis_ready.sv
// Per-axis ready flag tracker for the motion module I/O image.
// Assumes the connection inputs are synchronous to clk and reset is already synchronised.
`timescale 1ns/1ps
module mmios_axis_ready #(
	parameter int AXES = 32
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [AXES-1:0] axis_connected,
	input wire logic fieldbus_disconnect_command,
	output logic [AXES-1:0] axis_ready
);
	typedef struct packed {
		logic [AXES-1:0] held_off;
		logic [AXES-1:0] ready;
	} mmios_axis_state_t;

	mmios_axis_state_t state;
	mmios_axis_state_t next_state;

	// ----------------------------------------------------------------
	// Per-axis flag logic
	// ----------------------------------------------------------------
	// A disconnected axis stays off until its drive drops and reconnects.
	always_comb begin
		next_state = state;
		for (int i = 0; i < AXES; i++) begin
			if (fieldbus_disconnect_command) begin
				next_state.held_off[i] = 1'b1;
			end else if (!axis_connected[i]) begin
				next_state.held_off[i] = 1'b0;
			end
			next_state.ready[i] = axis_connected[i] & ~next_state.held_off[i];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign axis_ready = state.ready;
endmodule

// ### mmios_io_bank.sv
// Top of the motion module I/O status bank: three input words to the host, one command word from it.
// Assumes host strobes and status inputs are synchronous to clk.
`timescale 1ns/1ps
module mmios_io_bank #(
	parameter int AXES = mmios_pkg::MMIOS_AXES
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [1:0] host_addr,
	input wire logic host_rd,
	input wire logic host_wr,
	input wire logic [15:0] host_wdata,
	output logic [15:0] host_rdata,
	output logic host_rdata_valid,
	input wire logic host_cpu_run,
	input wire logic cable_attached,
	input wire logic hw_fault,
	input wire logic module_recognised,
	input wire logic error_state,
	input wire logic comm_state,
	input wire logic [AXES-1:0] axis_connected,
	input wire logic fieldbus_disconnect_command,
	output logic module_running
);
	typedef struct packed {
		logic [15:0] host_command_word;
		logic running;
		logic [15:0] module_status_word;
		logic [15:0] rdata;
		logic rdata_valid;
	} mmios_state_t;

	mmios_state_t state;
	mmios_state_t next_state;
	logic rst_sync1;
	logic rst_sync2;
	logic [AXES-1:0] axis_ready;
	logic [31:0] axis_image;
	logic [15:0] next_command_word;
	logic next_running;
	logic [15:0] next_status_word;

	// ----------------------------------------------------------------
	// Reset release
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_sync1 <= 1'b0;
			rst_sync2 <= 1'b0;
		end else begin
			rst_sync1 <= 1'b1;
			rst_sync2 <= rst_sync1;
		end
	end

	// ----------------------------------------------------------------
	// Axis flags
	// ----------------------------------------------------------------
	// Each axis flag is tracked on its own so that a disconnect can be held per axis.
	mmios_axis_ready #(
		.AXES(AXES)
	) u_axis_ready (
		.clk(clk),
		.rst_n(rst_sync2),
		.axis_connected(axis_connected),
		.fieldbus_disconnect_command(fieldbus_disconnect_command),
		.axis_ready(axis_ready)
	);

	// ----------------------------------------------------------------
	// Axis image
	// ----------------------------------------------------------------
	// Axis n sits at image bit n; bits past the configured axis count read as zero.
	for (genvar g = 0; g < 32; g++) begin : g_axis_image
		if (g < AXES) begin : g_used
			assign axis_image[g] = axis_ready[g];
		end else begin : g_unused
			assign axis_image[g] = 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Command word
	// ----------------------------------------------------------------
	// Only the command word takes host data; writes to the three input words are dropped.
	assign next_command_word = (host_wr && host_addr == mmios_pkg::MMIOS_OFS_COMMAND) ? host_wdata
		: state.host_command_word;

	// ----------------------------------------------------------------
	// Run state
	// ----------------------------------------------------------------
	// The module stops whenever the host CPU itself is not running, whatever the command says.
	assign next_running = host_cpu_run & ~next_command_word[mmios_pkg::MMIOS_CMD_STOP];

	// ----------------------------------------------------------------
	// Status word
	// ----------------------------------------------------------------
	// One branch per status bit; every bit without a function reads as zero.
	for (genvar b = 0; b < mmios_pkg::MMIOS_WORD_W; b++) begin : g_status_bit
		if (b == mmios_pkg::MMIOS_ST_STOP) begin : g_stop
			assign next_status_word[b] = ~next_running;
		end else if (b == mmios_pkg::MMIOS_ST_ERROR) begin : g_error
			assign next_status_word[b] = error_state;
		end else if (b == mmios_pkg::MMIOS_ST_COMM) begin : g_comm
			assign next_status_word[b] = comm_state;
		end else if (b == mmios_pkg::MMIOS_ST_LINK) begin : g_link
			assign next_status_word[b] = cable_attached;
		end else if (b == mmios_pkg::MMIOS_ST_READY) begin : g_ready
			assign next_status_word[b] = module_recognised & ~hw_fault;
		end else begin : g_unused
			assign next_status_word[b] = 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Read port
	// ----------------------------------------------------------------
	// A read answers one cycle later and the data then holds until the next read.
	always_comb begin
		next_state = state;
		next_state.host_command_word = next_command_word;
		next_state.running = next_running;
		next_state.module_status_word = next_status_word;
		next_state.rdata_valid = 1'b0;
		if (host_rd) begin
			next_state.rdata_valid = 1'b1;
			case (host_addr)
				mmios_pkg::MMIOS_OFS_STATUS: begin
					next_state.rdata = state.module_status_word;
				end
				mmios_pkg::MMIOS_OFS_AXIS_LOW: begin
					next_state.rdata = axis_image[15:0];
				end
				mmios_pkg::MMIOS_OFS_AXIS_HIGH: begin
					next_state.rdata = axis_image[31:16];
				end
				default: begin
					// The command word is write-only and reads back as zero.
					next_state.rdata = mmios_pkg::MMIOS_ZERO_WORD;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	// After reset the module is stopped and the command word asks for stop.
	always_ff @(posedge clk or negedge rst_sync2) begin
		if (!rst_sync2) begin
			state.host_command_word <= mmios_pkg::MMIOS_CMD_RESET;
			state.running <= 1'b0;
			state.module_status_word <= mmios_pkg::MMIOS_STATUS_RESET;
			state.rdata <= mmios_pkg::MMIOS_ZERO_WORD;
			state.rdata_valid <= 1'b0;
		end else begin
			state <= next_state;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign host_rdata = state.rdata;
	assign host_rdata_valid = state.rdata_valid;
	assign module_running = state.running;
endmodule

// ### mmios_monitor.sv
// Port checker of the motion module I/O bank.
// Assumes it is bound to mmios_io_bank and sees its ports only.
`timescale 1ns/1ps
module mmios_monitor (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [1:0] host_addr,
	input wire logic host_rd,
	input wire logic host_wr,
	input wire logic [15:0] host_wdata,
	input wire logic [15:0] host_rdata,
	input wire logic host_rdata_valid,
	input wire logic host_cpu_run,
	input wire logic module_running
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	rd_answer_a: assert property (host_rd |=> host_rdata_valid) else $error("read not answered");
	valid_cause_a: assert property (host_rdata_valid |-> $past(host_rd)) else $error("valid without read");
	rdata_hold_a: assert property (!host_rd |=> $stable(host_rdata)) else $error("read data moved");
	cmd_refused_a: assert property (host_rdata_valid && $past(host_addr) == 2'h3 |-> host_rdata == 16'h0000)
		else $error("command word read not zero");
	unused_zero_a: assert property (host_rdata_valid && $past(host_addr) == 2'h0 |-> host_rdata[13:3] == 11'h000)
		else $error("unused status bits set");
	cpu_gate_a: assert property (!host_cpu_run |=> !module_running) else $error("runs while host stopped");
	stop_cmd_a: assert property (host_wr && host_addr == 2'h3 && host_wdata[0] |=> !module_running)
		else $error("stop command ignored");
	run_cmd_a: assert property (host_wr && host_addr == 2'h3 && !host_wdata[0] && host_cpu_run |=> module_running)
		else $error("run command ignored");
endmodule
bind mmios_io_bank mmios_monitor i_mmios_monitor (.clk(clk), .rst_n(rst_n), .host_addr(host_addr),
	.host_rd(host_rd), .host_wr(host_wr), .host_wdata(host_wdata), .host_rdata(host_rdata),
	.host_rdata_valid(host_rdata_valid), .host_cpu_run(host_cpu_run), .module_running(module_running));

// ### mmios_host.sv
// Host CPU model: issues word reads and command writes.
// Assumes clk is the bank clock and reset has been released.
`timescale 1ns/1ps
module mmios_host (
	input wire logic clk,
	input wire logic [15:0] host_rdata,
	input wire logic host_rdata_valid,
	output logic [1:0] host_addr = 2'h0,
	output logic host_rd = 1'b0,
	output logic host_wr = 1'b0,
	output logic [15:0] host_wdata = 16'h0000
);
	task automatic access(input logic wr, input logic [1:0] a, input logic [15:0] d, output logic [16:0] q);
		@(posedge clk);
		host_addr <= a;
		host_rd <= !wr;
		host_wr <= wr;
		host_wdata <= d;
		@(posedge clk);
		host_rd <= 1'b0;
		host_wr <= 1'b0;
		@(posedge clk);
		q = {host_rdata_valid, host_rdata};
	endtask
endmodule

// ### mmios_io_bank_tb.sv
// Self-checking bench of the I/O bank driven through the host model.
// Assumes the checker and host model are compiled before it.
`timescale 1ns/1ps
module mmios_io_bank_tb;
	logic clk, rst_n = 1'b0, run = 1'b0, cab = 1'b0, flt = 1'b0, rec = 1'b0, err = 1'b0, com = 1'b0, dis = 1'b0;
	logic [31:0] axc = 32'h00000000;
	logic [1:0] addr;
	logic rd, wr, vld, running;
	logic [15:0] wd, rdat;
	logic [16:0] q;
	int errors = 0, n_compared = 0;
	mmios_io_bank i_mmios_io_bank (.clk(clk), .rst_n(rst_n), .host_addr(addr), .host_rd(rd), .host_wr(wr),
		.host_wdata(wd), .host_rdata(rdat), .host_rdata_valid(vld), .host_cpu_run(run), .cable_attached(cab),
		.hw_fault(flt), .module_recognised(rec), .error_state(err), .comm_state(com), .axis_connected(axc),
		.fieldbus_disconnect_command(dis), .module_running(running));
	mmios_host i_mmios_host (.clk(clk), .host_rdata(rdat), .host_rdata_valid(vld), .host_addr(addr),
		.host_rd(rd), .host_wr(wr), .host_wdata(wd));
	task automatic give_verdict;
		$display("errors %0d compared %0d", errors, n_compared);
		if (errors == 0 && n_compared > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input logic [1:0] a, input logic [15:0] e);
		i_mmios_host.access(1'b0, a, 16'h0000, q);
		n_compared++;
		if (q !== {1'b1, e}) begin
			$display("unexpected at %0t got %h expected %h", $time, q, {1'b1, e});
			errors++;
		end
	endtask
	task automatic chk_run(input logic e);
		n_compared++;
		if (running !== e) begin
			$display("unexpected at %0t got %h expected %h", $time, running, e);
			errors++;
		end
	endtask
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	initial begin
		repeat (3000) @(posedge clk);
		errors++;
		give_verdict();
	end
	initial begin
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		chk(2'h0, 16'h0001);
		chk(2'h3, 16'h0000);
		{run, cab, rec, err, com, axc} <= {5'h1F, 32'hA5C30001};
		i_mmios_host.access(1'b1, 2'h3, 16'h0000, q);
		repeat (4) @(posedge clk);
		chk(2'h0, 16'hC006);
		chk(2'h1, 16'h0001);
		flt <= 1'b1;
		cab <= 1'b0;
		i_mmios_host.access(1'b1, 2'h3, 16'h0001, q);
		repeat (4) @(posedge clk);
		chk(2'h0, 16'h0007);
		chk(2'h2, 16'hA5C3);
		dis <= 1'b1;
		@(posedge clk);
		dis <= 1'b0;
		repeat (4) @(posedge clk);
		chk(2'h1, 16'h0000);
		chk(2'h2, 16'h0000);
		axc <= 32'hA5C30000;
		repeat (2) @(posedge clk);
		axc <= 32'hA5C30001;
		repeat (4) @(posedge clk);
		chk(2'h1, 16'h0001);
		chk(2'h2, 16'h0000);
		i_mmios_host.access(1'b1, 2'h3, 16'h0000, q);
		i_mmios_host.access(1'b1, 2'h0, 16'h0001, q);
		repeat (2) @(posedge clk);
		chk_run(1'b1);
		chk(2'h0, 16'h0006);
		run <= 1'b0;
		repeat (2) @(posedge clk);
		chk_run(1'b0);
		chk(2'h0, 16'h0007);
		run <= 1'b1;
		rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		chk_run(1'b0);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		chk(2'h0, 16'h0007);
		chk(2'h2, 16'hA5C3);
		give_verdict();
	end
endmodule
